/* verilog/fan_pwm_supervisor.sv */
/*
 fan_pwm_supervisor: fan pwm drive with start-up, diagnostic and missing-pulse supervision,
 shutdown and auto-shutdown handling, alarm output and an ahb-lite register slave.
 assumes comparator bits and the duty code are synchronous to hclk; the fan pulse is not.
*/
// The placing of the registers and the AHB-Lite slave port were decided locally.
// Operation
// (RQ1) fan start from off drives output on for 32 full pwm periods; here a seen fan pulse ends start-up early
// (RQ2) start-up timer counts pwm periods, not independent clock
// (RQ3) fan fault runs diagnostic once, then start-up, then latches shutdown
// (RQ4) duty rises linearly with control code, 0% to 100%
// (RQ5) drive on while ramp is below control threshold each period
// (RQ6) control at or below shutdown level enters shutdown, stopping everything
// (RQ7) alarm stays inactive in shutdown
// (RQ8) shutdown left only when control reaches release level
// (RQ9) control at or below auto-shutdown threshold switches fan off
// (RQ10) auto-shutdown left only above threshold plus hysteresis
// (RQ11) any fault pulls the active-low alarm low
// (RQ12) fan-fault alarm latches shutdown until shutdown input or power cycle
// (RQ13) alarm asserted at full duty while fan keeps running
// (RQ14) over-temperature alarm releases once duty drops below full
// (RQ15) fan drive is active high
// (RQ16) system picks ramp timing for roughly 30 Hz pwm
// (RQ17) thirty-two periods without fan pulse report a fan fault
// (RQ18) diagnostic holds drive high for three periods watching for pulses
// (RQ19) fan pulses right after drive turn-on are blanked
// (RQ20) alarm stays inactive in auto-shutdown
// (RQ21) comparisons arrive as bits, control level as a duty code
// (RQ22) fan pulse synchronised, edge-detected, resets missing-pulse count
// (RQ23) entering shutdown clears timers and latched fault
module fan_pwm_supervisor
	import fan_pwm_pkg::*;
#(
	parameter logic [15:0] STEP_DIV = CFG_RESET
)
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic [7:0]  temp_control_input,
	input  wire logic        shutdown_level_hit,
	input  wire logic        release_level_hit,
	input  wire logic        autoshutdown_hit,
	input  wire logic        autoshutdown_restart_hit,
	input  wire logic        full_duty_hit,
	input  wire logic        fan_pulse_in,
	output logic             fan_drive_output,
	input  wire logic        alarm_n_in,
	output logic             alarm_n_out,
	output logic             alarm_n_oe
);
	pwm_timebase_if tbus ();

	pwm_timebase u_timebase (
		.hclk    (hclk),
		.hresetn (hresetn),
		.tb      (tbus.tb)
	);

	sup_state_type state_ff;
	sup_state_type nxt_state;
	logic [5:0]    cnt_ff;
	logic [5:0]    nxt_cnt;
	logic [7:0]    duty_ff;
	logic [7:0]    nxt_duty;
	logic          drive_ff;
	logic          nxt_drive;
	logic          alarm_ff;
	logic          nxt_alarm;
	logic          restart;
	logic          active;
	logic          sense_meta_ff;
	logic          sense_sync_ff;
	logic          sense_last_ff;
	logic [11:0]   blank_ff;
	logic [11:0]   nxt_blank;
	logic          pulse_seen;
	logic [15:0]   div_ff;
	logic [15:0]   nxt_div;
	logic          wr_pend_ff;
	logic          nxt_wr_pend;
	logic [11:0]   wr_addr_ff;
	logic [11:0]   nxt_wr_addr;
	logic [31:0]   rdata_ff;
	logic [31:0]   nxt_rdata;
	logic          addr_phase;
	logic          ready_ff;

	function automatic logic [31:0] read_reg(input logic [11:0] addr);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (addr)
			CFG_OFFSET:
				v[15:0] = div_ff;
			STATUS_OFFSET:
			begin
				v[ST_DRIVE_BIT] = drive_ff;
				v[ST_ALARM_BIT] = alarm_ff;
				v[ST_FAULT_BIT] = (state_ff == FAULT_LATCH);
				v[ST_SHDN_BIT]  = (state_ff == SHUTDOWN);
				v[ST_AUTO_BIT]  = (state_ff == AUTO_OFF);
				v[ST_RUN_BIT]   = (state_ff == RUNNING);
				v[ST_CNT_POS +: 6]   = cnt_ff;
				v[ST_STATE_POS +: 3] = state_ff;
			end
			DUTY_OFFSET:
				v[7:0] = duty_ff;
			default:
				v = 32'h0000_0000;
		endcase
		return v;
	endfunction : read_reg

	// ahb-lite slave: zero wait states, always okay; unmapped reads return zero
	assign addr_phase = hsel && hready && htrans[1];

	always_comb
	begin
		nxt_wr_pend = 1'b0;
		nxt_wr_addr = wr_addr_ff;
		nxt_rdata   = rdata_ff;
		nxt_div     = div_ff;
		if (wr_pend_ff && wr_addr_ff == CFG_OFFSET)
			nxt_div = hwdata[15:0];
		if (addr_phase)
		begin
			nxt_wr_pend = hwrite;
			nxt_wr_addr = {haddr[11:2], 2'b00};
			if (!hwrite)
				nxt_rdata = read_reg({haddr[11:2], 2'b00});
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 12'h000;
			rdata_ff   <= 32'h0000_0000;
			div_ff     <= STEP_DIV;
			ready_ff   <= 1'b0;
		end
		else
		begin
			wr_pend_ff <= nxt_wr_pend;
			wr_addr_ff <= nxt_wr_addr;
			rdata_ff   <= nxt_rdata;
			div_ff     <= nxt_div;
			ready_ff   <= 1'b1;
		end
	end

	// the parameter only sets the reset divider, so a read of cfg shows what the ramp uses
	assign tbus.step_div = div_ff;
	assign hrdata        = rdata_ff;
	assign hreadyout     = ready_ff;
	assign hresp         = 1'b0;

	// fan pulse: two-stage synchroniser, then edge detect on the settled stage
	assign pulse_seen = sense_sync_ff && !sense_last_ff && (blank_ff == 12'h000); // see (RQ19)

	always_comb
	begin
		nxt_blank = (blank_ff != 12'h000) ? blank_ff - 12'h001 : 12'h000;
		if (nxt_drive && !drive_ff)
			nxt_blank = 12'(BLANK_CYCLES); // see (RQ19)
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sense_meta_ff <= 1'b0;
			sense_sync_ff <= 1'b0;
			sense_last_ff <= 1'b0;
			blank_ff      <= 12'h000;
		end
		else
		begin
			sense_meta_ff <= fan_pulse_in; // see (RQ22)
			sense_sync_ff <= sense_meta_ff;
			sense_last_ff <= sense_sync_ff;
			blank_ff      <= nxt_blank;
		end
	end

	// supervision sequencer; start-up, diagnostic and retry timers count whole pwm periods from a restarted ramp
	assign active = (state_ff == STARTUP) || (state_ff == RUNNING) ||
	                (state_ff == DIAG) || (state_ff == RETRY);

	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		restart   = 1'b0;
		nxt_duty  = tbus.period_start ? temp_control_input : duty_ff; // see (RQ21)
		if (shutdown_level_hit)
		begin
			nxt_state = SHUTDOWN; // see (RQ6) (RQ23)
			nxt_cnt   = 6'h00;
		end
		else
		begin
			case (state_ff)
				SHUTDOWN:
					if (release_level_hit) // see (RQ8)
					begin
						if (autoshutdown_restart_hit && !autoshutdown_hit)
						begin
							nxt_state = STARTUP; // see (RQ1)
							restart   = 1'b1;
						end
						else
							nxt_state = AUTO_OFF;
					end
				AUTO_OFF:
					if (autoshutdown_restart_hit && !autoshutdown_hit) // see (RQ10)
					begin
						nxt_state = STARTUP; // see (RQ1)
						nxt_cnt   = 6'h00;
						restart   = 1'b1;
					end
				FAULT_LATCH:
					nxt_state = FAULT_LATCH; // see (RQ12)
				default:
				begin
					if (autoshutdown_hit)
					begin
						nxt_state = AUTO_OFF; // see (RQ9)
						nxt_cnt   = 6'h00;
					end
					else if (pulse_seen)
					begin
						nxt_state = RUNNING; // see (RQ22)
						nxt_cnt   = 6'h00;
					end
					else if (tbus.period_start)
					begin
						nxt_cnt = cnt_ff + 6'h01; // see (RQ2)
						if (state_ff == RUNNING && nxt_cnt == MISSING_PERIODS)
						begin
							nxt_state = DIAG; // see (RQ17) (RQ3)
							nxt_cnt   = 6'h00;
							restart   = 1'b1;
						end
						else if (state_ff == DIAG && nxt_cnt == DIAG_PERIODS)
						begin
							nxt_state = RETRY; // see (RQ3)
							nxt_cnt   = 6'h00;
							restart   = 1'b1;
						end
						else if (state_ff == STARTUP && nxt_cnt == STARTUP_PERIODS)
						begin
							nxt_state = RUNNING; // see (RQ1)
							nxt_cnt   = 6'h00;
						end
						else if (state_ff == RETRY && nxt_cnt == STARTUP_PERIODS)
						begin
							nxt_state = FAULT_LATCH; // see (RQ3) (RQ12)
							nxt_cnt   = 6'h00;
						end
					end
				end
			endcase
		end
		if (restart)
			nxt_duty = temp_control_input;
		nxt_drive = 1'b0;
		case (nxt_state)
			STARTUP,
			DIAG,
			RETRY:
				nxt_drive = 1'b1; // see (RQ1) (RQ18) (RQ15)
			RUNNING:
				nxt_drive = (duty_ff == DUTY_FULL) || (tbus.ramp < duty_ff); // see (RQ4) (RQ5)
			default:
				nxt_drive = 1'b0;
		endcase
		// over-temperature warning is live only while the fan runs, and never latches
		nxt_alarm = (nxt_state == FAULT_LATCH) ||
		            (active && (nxt_state != AUTO_OFF) && (nxt_state != SHUTDOWN) &&
		             full_duty_hit); // see (RQ11) (RQ13) (RQ14) (RQ7) (RQ20)
	end

	assign tbus.restart = restart;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_ff <= SHUTDOWN;
			cnt_ff   <= 6'h00;
			duty_ff  <= 8'h00;
			drive_ff <= 1'b0;
			alarm_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			duty_ff  <= nxt_duty;
			drive_ff <= nxt_drive;
			alarm_ff <= nxt_alarm;
		end
	end

	// open-drain alarm: only ever pulls low
	assign fan_drive_output = drive_ff;
	assign alarm_n_out      = 1'b0;
	assign alarm_n_oe       = alarm_ff;

	a_shdn_entry: assert property (@(posedge hclk) disable iff (!hresetn) // see (RQ6)
		shutdown_level_hit |=> state_ff == SHUTDOWN && !drive_ff)
		else $error("shutdown level did not stop the fan");
	a_shdn_alarm_off: assert property (@(posedge hclk) disable iff (!hresetn) // see (RQ7)
		shutdown_level_hit |=> !alarm_n_oe)
		else $error("alarm active in shutdown");
	a_shdn_hold: assert property (@(posedge hclk) disable iff (!hresetn) // see (RQ8)
		state_ff == SHUTDOWN && !release_level_hit |=> state_ff == SHUTDOWN)
		else $error("left shutdown below release level");
	a_auto_entry: assert property (@(posedge hclk) disable iff (!hresetn) // see (RQ9)
		active && autoshutdown_hit && !shutdown_level_hit |=> state_ff == AUTO_OFF && !drive_ff)
		else $error("auto-shutdown did not stop the fan");
	a_auto_alarm_off: assert property (@(posedge hclk) disable iff (!hresetn) // see (RQ20)
		state_ff == AUTO_OFF ##1 state_ff == AUTO_OFF |-> !alarm_n_oe)
		else $error("alarm active in auto-shutdown");
	a_auto_hold: assert property (@(posedge hclk) disable iff (!hresetn) // see (RQ10)
		state_ff == AUTO_OFF && !autoshutdown_restart_hit |=> state_ff != STARTUP)
		else $error("restart below auto-shutdown hysteresis");
	a_startup_len: assert property (@(posedge hclk) disable iff (!hresetn) // see (RQ1)
		state_ff == STARTUP && cnt_ff < 6'h1F && !pulse_seen && !autoshutdown_hit &&
		!shutdown_level_hit |=> state_ff == STARTUP && drive_ff)
		else $error("start-up left early");
	a_startup_drive: assert property (@(posedge hclk) disable iff (!hresetn) // see (RQ18)
		(state_ff == DIAG || state_ff == STARTUP) ##1 (state_ff == DIAG || state_ff == STARTUP)
		|-> drive_ff)
		else $error("drive not held high in timed state");
	a_miss_timeout: assert property (@(posedge hclk) disable iff (!hresetn) // see (RQ17)
		state_ff == RUNNING && cnt_ff == 6'h1F && tbus.period_start && !pulse_seen &&
		!autoshutdown_hit && !shutdown_level_hit |=> state_ff == DIAG)
		else $error("missing-pulse timeout not taken");
	a_fault_latch: assert property (@(posedge hclk) disable iff (!hresetn) // see (RQ12)
		state_ff == FAULT_LATCH && !shutdown_level_hit |=> state_ff == FAULT_LATCH && alarm_n_oe
		&& !drive_ff)
		else $error("fan fault latch released");
	a_otemp_alarm: assert property (@(posedge hclk) disable iff (!hresetn) // see (RQ13)
		state_ff == RUNNING && full_duty_hit && !autoshutdown_hit && !shutdown_level_hit
		|=> alarm_n_oe)
		else $error("over-temperature alarm missing");
	a_otemp_release: assert property (@(posedge hclk) disable iff (!hresetn) // see (RQ14)
		state_ff == RUNNING && !full_duty_hit |=> !alarm_n_oe)
		else $error("over-temperature alarm latched");
	a_pwm_compare: assert property (@(posedge hclk) disable iff (!hresetn) // see (RQ5)
		state_ff == RUNNING ##1 state_ff == RUNNING |-> drive_ff ==
		($past(duty_ff) == DUTY_FULL || $past(tbus.ramp) < $past(duty_ff)))
		else $error("pwm compare mismatch");
endmodule : fan_pwm_supervisor

/* verilog/fan_pwm_pkg.sv */
/*
 fan_pwm_pkg: constants, register map and state encoding for the fan pwm supervisor.
 assumes a single 250 MHz clock; all analog comparisons arrive as clean bits.
*/
package fan_pwm_pkg;
	// timing base
	localparam int unsigned CLK_HZ          = 250_000_000;
	localparam int unsigned PWM_HZ          = 30;
	localparam int unsigned RAMP_STEPS      = 255;
	localparam int unsigned STEP_DIV_CYCLES = CLK_HZ / (PWM_HZ * RAMP_STEPS);
	localparam int unsigned BLANK_US        = 10;
	localparam int unsigned BLANK_CYCLES    = (BLANK_US * (CLK_HZ / 1_000_000) > 0) ?
	                                          BLANK_US * (CLK_HZ / 1_000_000) : 1;
	// period counts of the supervision timers
	localparam logic [5:0] STARTUP_PERIODS = 6'h20;
	localparam logic [5:0] DIAG_PERIODS    = 6'h03;
	localparam logic [5:0] MISSING_PERIODS = 6'h20;
	// duty and ramp
	localparam int unsigned DUTY_W    = 8;
	localparam logic [7:0]  RAMP_LAST = 8'hFE;
	localparam logic [7:0]  DUTY_FULL = 8'hFF;
	// register map (byte addresses)
	localparam logic [11:0] CFG_OFFSET    = 12'h000;
	localparam logic [11:0] STATUS_OFFSET = 12'h004;
	localparam logic [11:0] DUTY_OFFSET   = 12'h008;
	localparam logic [15:0] CFG_RESET     = 16'(STEP_DIV_CYCLES);
	// status fields
	localparam int unsigned ST_DRIVE_BIT = 0;
	localparam int unsigned ST_ALARM_BIT = 1;
	localparam int unsigned ST_FAULT_BIT = 2;
	localparam int unsigned ST_SHDN_BIT  = 3;
	localparam int unsigned ST_AUTO_BIT  = 4;
	localparam int unsigned ST_RUN_BIT   = 5;
	localparam int unsigned ST_CNT_POS   = 8;
	localparam int unsigned ST_STATE_POS = 16;

	typedef enum logic [2:0] {
		SHUTDOWN,
		AUTO_OFF,
		STARTUP,
		RUNNING,
		DIAG,
		RETRY,
		FAULT_LATCH
	} sup_state_type;
endpackage : fan_pwm_pkg

/* verilog/pwm_timebase_if.sv */
/*
 pwm_timebase_if: carries the ramp and period tick between the supervisor and its timebase.
 assumes both ends run on the same clock.
*/
interface pwm_timebase_if;
	logic [15:0] step_div;
	logic        restart;
	logic [7:0]  ramp;
	logic        period_start;

	modport sup (output step_div, output restart, input ramp, input period_start);
	modport tb  (input step_div, input restart, output ramp, output period_start);
endinterface : pwm_timebase_if

/* verilog/pwm_timebase.sv */
/*
 pwm_timebase: prescaler and ramp counter of the pwm; one ramp sweep is one pwm period.
 assumes step_div is stable between writes; a zero divider behaves as one.
*/
module pwm_timebase
	import fan_pwm_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	pwm_timebase_if.tb tb
);
	logic [15:0] pre_ff;
	logic [15:0] nxt_pre;
	logic [7:0]  ramp_ff;
	logic [7:0]  nxt_ramp;
	logic        tick_ff;
	logic        nxt_tick;

	always_comb
	begin
		nxt_pre  = pre_ff + 16'h0001;
		nxt_ramp = ramp_ff;
		nxt_tick = 1'b0;
		if (tb.restart)
		begin
			nxt_pre  = 16'h0000;
			nxt_ramp = 8'h00;
		end
		else if (pre_ff + 16'h0001 >= tb.step_div)
		begin
			nxt_pre = 16'h0000;
			if (ramp_ff >= RAMP_LAST)
			begin
				nxt_ramp = 8'h00;
				nxt_tick = 1'b1;
			end
			else
				nxt_ramp = ramp_ff + 8'h01;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pre_ff  <= 16'h0000;
			ramp_ff <= 8'h00;
			tick_ff <= 1'b0;
		end
		else
		begin
			pre_ff  <= nxt_pre;
			ramp_ff <= nxt_ramp;
			tick_ff <= nxt_tick;
		end
	end

	assign tb.ramp         = ramp_ff;
	assign tb.period_start = tick_ff;

	a_ramp_bound: assert property (@(posedge hclk) disable iff (!hresetn)
		ramp_ff <= RAMP_LAST) else $error("ramp ran past its last step"); // see (RQ5)
endmodule : pwm_timebase

/* verification/fan_model.sv */
/*
 fan_model: brushless fan seen through its sense resistor, reduced to a pulse source.
 assumes drive is sampled on hclk; mode is set by the testbench.
*/
module fan_model
(
	input  wire logic       hclk,
	input  wire logic       drive,
	input  wire logic [1:0] mode,
	output logic            pulse
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [8:0]  spin_ff  = 9'h000;
	logic [11:0] since_ff = 12'hFFF;
	logic        drv_q_ff = 1'b0;
	logic        pulse_ff = 1'b0;
	assign pulse = pulse_ff;
	// mode 0 stalled, 1 turning, 2 only the spike that follows each turn-on
	always @(posedge hclk)
	begin
		spin_ff <= (spin_ff == 9'h18F) ? 9'h000 : spin_ff + 9'h001;
		drv_q_ff <= drive;
		if (drive && !drv_q_ff)
			since_ff <= 12'h000;
		else if (since_ff != 12'hFFF)
			since_ff <= since_ff + 12'h001;
		case (mode)
			2'h1: pulse_ff <= drive && (spin_ff < 9'h014);
			2'h2: pulse_ff <= (since_ff >= 12'h064) && (since_ff < 12'h078);
			default: pulse_ff <= 1'b0;
		endcase
	end
endmodule : fan_model

/* verification/test_fan_pwm_supervisor.sv */
/*
 test_fan_pwm_supervisor: directed bench for the fan pwm supervisor driving a fan model.
 assumes a shortened prescaler of 2, so one pwm period is 510 clocks.
*/
module test_fan_pwm_supervisor
	import fan_pwm_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// short prescaler stands in for the ~30 Hz timing element
	localparam logic [15:0] DIV   = 16'h0002;
	localparam int          PER   = 510;
	localparam int          LIMIT = 100000;
	localparam logic [31:0] A_CFG = {20'h0, CFG_OFFSET};
	localparam logic [31:0] A_ST  = {20'h0, STATUS_OFFSET};
	localparam logic [31:0] A_DTY = {20'h0, DUTY_OFFSET};
	logic        hclk     = 1'b0;
	logic        hresetn  = 1'b0;
	logic        hsel     = 1'b0;
	logic [31:0] haddr    = 32'h0;
	logic [1:0]  htrans   = 2'h0;
	logic        hwrite   = 1'b0;
	logic [31:0] hwdata   = 32'h0;
	logic [7:0]  temp     = 8'hFF;
	logic        shdn_hit = 1'b0;
	logic        rel_hit  = 1'b1;
	logic        as_hit   = 1'b0;
	logic        rst_hit  = 1'b1;
	logic        full_hit = 1'b0;
	logic [1:0]  mode     = 2'h0;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        drive;
	logic        pulse;
	logic        al_out;
	logic        al_oe;
	int          bad_count;
	int          total_checks;
	int          cyc;
	// open-drain alarm with its pull-up
	wire         al_pin = al_oe ? al_out : 1'b1;
	always #2 hclk = ~hclk;
	fan_pwm_supervisor #(.STEP_DIV(DIV)) i_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.temp_control_input(temp), .shutdown_level_hit(shdn_hit),
		.release_level_hit(rel_hit), .autoshutdown_hit(as_hit),
		.autoshutdown_restart_hit(rst_hit), .full_duty_hit(full_hit),
		.fan_pulse_in(pulse), .fan_drive_output(drive), .alarm_n_in(al_pin),
		.alarm_n_out(al_out), .alarm_n_oe(al_oe));
	fan_model i_fan (.hclk(hclk), .drive(drive), .mode(mode), .pulse(pulse));
	task stop_test;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks = total_checks + 1;
		if (seen !== exp)
		begin
			bad_count = bad_count + 1;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		if (cyc == LIMIT)
		begin
			bad_count = bad_count + 1;
			stop_test();
		end
	end
	task ahb(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : ahb
	task wait_state(input logic [2:0] s, input int lim, output logic [31:0] r);
		int n;
		n = 0;
		do
		begin
			ahb(A_ST, 1'b0, 32'h0, r);
			n = n + 3;
		end
		while (r[18:16] !== s && n < lim);
	endtask : wait_state
	task count_high(input int len, output int h);
		h = 0;
		repeat (len)
		begin
			@(posedge hclk);
			if (drive === 1'b1)
				h = h + 1;
		end
	endtask : count_high
	task s_startup;
		int h;
		logic [31:0] r;
		repeat (2) @(posedge hclk);
		count_high(16000, h);
		chk("startup_high", h, 16000);
		ahb(A_ST, 1'b0, 32'h0, r);
		chk("startup_state", r[18:16], STARTUP);
		repeat (400) @(posedge hclk);
		ahb(A_ST, 1'b0, 32'h0, r);
		chk("run_state", r[18:16], RUNNING);
		mode <= 2'h1;
		ahb(A_CFG, 1'b0, 32'h0, r);
		chk("cfg_reset", r, 32'(DIV));
		ahb(32'h0000_000C, 1'b1, 32'hFFFF_FFFF, r);
		ahb(32'h0000_000C, 1'b0, 32'h0, r);
		chk("unmapped", r, 32'h0);
		chk("hresp_okay", hresp, 32'h0);
	endtask : s_startup
	task s_duty;
		int h;
		logic [31:0] r;
		temp <= 8'h80;
		repeat (2 * PER) @(posedge hclk);
		count_high(PER, h);
		chk("duty_half", h, 256);
		ahb(A_DTY, 1'b0, 32'h0, r);
		chk("duty_reg", r[7:0], 8'h80);
		temp <= 8'h00;
		repeat (2 * PER) @(posedge hclk);
		count_high(PER, h);
		chk("duty_zero", h, 0);
		temp <= 8'hFF;
		repeat (2 * PER) @(posedge hclk);
		count_high(PER, h);
		chk("duty_full", h, PER);
	endtask : s_duty
	task s_overtemp;
		logic [31:0] r;
		full_hit <= 1'b1;
		repeat (3) @(posedge hclk);
		chk("ot_alarm", al_pin, 1'b0);
		chk("ot_drive", drive, 1'b1);
		full_hit <= 1'b0;
		repeat (3) @(posedge hclk);
		chk("ot_release", al_oe, 1'b0);
		ahb(A_ST, 1'b0, 32'h0, r);
		chk("pulses_keep_run", r[18:16], RUNNING);
	endtask : s_overtemp
	task s_fault;
		int n;
		logic [31:0] r;
		n = 0;
		// the count may have run on while pulses were blanked; start it from a seen pulse
		do
		begin
			ahb(A_ST, 1'b0, 32'h0, r);
			n = n + 3;
		end
		while (r[13:8] !== 6'h00 && n < 8000);
		chk("pulse_resets_count", r[13:8], 6'h00);
		n = 0;
		mode <= 2'h0;
		while (al_oe !== 1'b1 && n < 70 * PER)
		begin
			@(posedge hclk);
			n = n + 1;
		end
		chk("fault_delay", 32'(n > 65 * PER && n < 68 * PER), 32'h1);
		repeat (1000) @(posedge hclk);
		chk("fault_drive", drive, 1'b0);
		chk("fault_alarm", al_pin, 1'b0);
		ahb(A_ST, 1'b0, 32'h0, r);
		chk("fault_state", r[18:16], FAULT_LATCH);
	endtask : s_fault
	task s_shutdown;
		logic [31:0] r;
		mode <= 2'h2;
		shdn_hit <= 1'b1;
		rel_hit <= 1'b0;
		rst_hit <= 1'b0;
		as_hit <= 1'b1;
		full_hit <= 1'b1;
		repeat (3) @(posedge hclk);
		chk("shdn_alarm", al_oe, 1'b0);
		chk("shdn_drive", drive, 1'b0);
		shdn_hit <= 1'b0;
		ahb(A_ST, 1'b0, 32'h0, r);
		chk("shdn_state", r[18:16], SHUTDOWN);
		chk("shdn_clear", r[ST_FAULT_BIT], 1'b0);
		rel_hit <= 1'b1;
		ahb(A_ST, 1'b0, 32'h0, r);
		chk("auto_state", r[18:16], AUTO_OFF);
		chk("auto_alarm", al_oe, 1'b0);
		as_hit <= 1'b0;
		ahb(A_ST, 1'b0, 32'h0, r);
		chk("auto_hold", r[18:16], AUTO_OFF);
		full_hit <= 1'b0;
		temp <= 8'h80;
		rst_hit <= 1'b1;
		repeat (3) @(posedge hclk);
		chk("restart_drive", drive, 1'b1);
		as_hit <= 1'b1;
		rst_hit <= 1'b0;
		repeat (3) @(posedge hclk);
		chk("auto_from_run", drive, 1'b0);
		ahb(A_ST, 1'b0, 32'h0, r);
		chk("auto_from_run_state", r[18:16], AUTO_OFF);
		as_hit <= 1'b0;
		rst_hit <= 1'b1;
		repeat (3) @(posedge hclk);
		chk("restart_again", drive, 1'b1);
	endtask : s_shutdown
	task s_blank;
		logic [31:0] r;
		wait_state(RUNNING, 17000, r);
		chk("blank_run", r[18:16], RUNNING);
		wait_state(DIAG, 17500, r);
		chk("blank_diag", r[18:16], DIAG);
	endtask : s_blank
	initial
	begin
		bad_count = 0;
		total_checks = 0;
		cyc = 0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		s_startup();
		s_duty();
		s_overtemp();
		s_fault();
		s_shutdown();
		s_blank();
		stop_test();
	end
endmodule : test_fan_pwm_supervisor
